/* include/msms_pkg.sv */
// Purpose: Shared constants for the motor stop-mode sequencer
// Assumes: 40 MHz aclk, settings in 0.01 units (Hz or s)
// Notes:   Register offsets are byte addresses on AXI4-Lite
`default_nettype none
package msms_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_NS       = 10_000_000;  // 0.01 s setting unit
   localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

   // Register offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_FREQ   = 8'h04;
   localparam logic [7:0] OFF_BLANK  = 8'h08;
   localparam logic [7:0] OFF_TIME   = 8'h0C;
   localparam logic [7:0] OFF_LEVEL  = 8'h10;
   localparam logic [7:0] OFF_BUSLIM = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;

   // Field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_PROT_LSB = 8;
   localparam int PROT_STALL_BIT = 3;

   // Reset values
   localparam logic [2:0]  RST_MODE   = 3'h0;
   localparam logic [7:0]  RST_PROT   = 8'h00;
   localparam logic [15:0] RST_FREQ   = 16'h01F4;  // 5.00 Hz
   localparam logic [15:0] RST_BLANK  = 16'h000A;  // 0.10 s
   localparam logic [15:0] RST_TIME   = 16'h0064;  // 1.00 s
   localparam logic [7:0]  RST_LEVEL  = 8'h32;     // 50 percent
   localparam logic [11:0] RST_BUSLIM = 12'hC00;

   // Upper limits of settings and the reaccel bus margin
   localparam logic [15:0] MAX_FREQ  = 16'h1770;   // 60.00 Hz
   localparam logic [15:0] MAX_TIME  = 16'h1770;   // 60.00 s
   localparam logic [7:0]  MAX_LEVEL = 8'hC8;      // 200 percent
   localparam logic [11:0] REACCEL_MARGIN = 12'h040;

   // Stop mode selector codes
   localparam logic [2:0] SEL_DEC   = 3'h0;
   localparam logic [2:0] SEL_DC    = 3'h1;
   localparam logic [2:0] SEL_COAST = 3'h2;
   localparam logic [2:0] SEL_POWER = 3'h4;

   typedef enum logic [1:0] {
      MSMS_MODE_DEC, MSMS_MODE_DC, MSMS_MODE_COAST, MSMS_MODE_POWER
   } msms_mode_t;

   typedef enum logic [2:0] {
      MSMS_IDLE    = 3'b000,
      MSMS_RUN     = 3'b001,
      MSMS_DECEL   = 3'b011,
      MSMS_BLANK   = 3'b010,
      MSMS_INJECT  = 3'b110,
      MSMS_STOPPED = 3'b111
   } msms_state_t;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : msms_pkg
`default_nettype wire

/* hw/msms_sync2.sv */
// Purpose: Two-flop synchroniser for a level from a pin
// Assumes: Single aclk domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module msms_sync2 (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic d,
   output var  logic q
);
   logic stage1;

   // Two stages, cleared on reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= 1'b0;
         q      <= 1'b0;
      end else begin
         stage1 <= d;
         q      <= stage1;
      end
   end
endmodule : msms_sync2
`default_nettype wire

/* hw/msms_timer.sv */
// Purpose: Interval timer counting settings in 0.01 s units
// Assumes: load is a one-cycle pulse
// Notes:   done is high while the count is zero, low in a load cycle
`timescale 1ns/10ps
`default_nettype none
module msms_timer #(
   parameter int TICK_CYCLES = msms_pkg::TICK_CYCLES,
   parameter int WIDTH       = 16
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_val,
   output var  logic             done
);
   logic [WIDTH-1:0] units;
   logic [31:0]      pre;

   // Prescaler restarts with every load
   always_ff @(posedge aclk) begin
      if (!aresetn || load || pre == 32'(TICK_CYCLES - 1)) begin
         pre <= 32'h0;
      end else begin
         pre <= pre + 32'h1;
      end
   end

   // Unit counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         units <= '0;
      end else if (load) begin
         units <= load_val;
      end else if (pre == 32'(TICK_CYCLES - 1) && units != '0) begin
         units <= units - 1'b1;
      end
   end

   assign done = (units == '0) && !load;
endmodule : msms_timer
`default_nettype wire

/* hw/msms_seq.sv */
// Purpose: Stop-mode sequencer: ramp, DC brake, coast, power braking
// Assumes: Frequencies in 0.01 Hz, from ramp logic on aclk
// Notes:   Settings and status over AXI4-Lite; run_cmd is a pin
`timescale 1ns/10ps
`default_nettype none
module msms_seq #(
   parameter int TICK_CYCLES = msms_pkg::TICK_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        run_cmd,
   input  wire logic [15:0] out_freq,
   input  wire logic        ramp_decel,
   input  wire logic [15:0] dwell_freq,
   input  wire logic [11:0] dcbus_volt,
   output var  logic        ramp_to_zero,
   output var  logic        output_enable,
   output var  logic        inj_active,
   output var  logic [7:0]  inj_current_ref,
   output var  logic        dwell_skip,
   output var  logic        slope_reduce,
   output var  logic        reaccel,
   output var  logic        stall_prev_en,
   output var  logic        stopped
);
   logic [2:0]  stop_mode;
   logic [7:0]  protection_option_bits;
   logic [15:0] injection_start_frequency;
   logic [15:0] output_blank_interval;
   logic [15:0] injection_time_setting;
   logic [7:0]  injection_current_setting;
   logic [11:0] bus_limit;
   logic        aw_full, w_full, run_s, blank_done, inj_done;
   logic [7:0]  aw_addr;
   logic [31:0] w_data, wr_val;
   logic [3:0]  w_strb;
   logic        do_write, decel_now, bus_high;
   msms_pkg::msms_mode_t  mode;
   msms_pkg::msms_state_t state, next_state;

   // Byte-lane merge of write data into a current value
   function automatic logic [31:0] msms_merge(input logic [31:0] cur,
         input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] r;
      r = cur;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : msms_merge

   msms_sync2 u_run_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (run_cmd),
      .q       (run_s)
   );

   always_comb begin
      case (stop_mode)
         msms_pkg::SEL_DC:    mode = msms_pkg::MSMS_MODE_DC;
         msms_pkg::SEL_COAST: mode = msms_pkg::MSMS_MODE_COAST;
         msms_pkg::SEL_POWER: mode = msms_pkg::MSMS_MODE_POWER;
         default:             mode = msms_pkg::MSMS_MODE_DEC;
      endcase
   end

   // AXI write channel capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_full <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_full <= 1'b0;
         end
      end
   end

   assign do_write = aw_full && w_full && !s_axi_bvalid;

   // Ready flags and write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= msms_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_full && !(s_axi_wvalid && s_axi_wready);
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == msms_pkg::OFF_STATUS ||
                             aw_addr > msms_pkg::OFF_STATUS ||
                             aw_addr[1:0] != 2'h0) ?
                            msms_pkg::RESP_SLVERR : msms_pkg::RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Setting registers; frequency, times and level clamped to their ranges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_mode                 <= msms_pkg::RST_MODE;
         protection_option_bits    <= msms_pkg::RST_PROT;
         injection_start_frequency <= msms_pkg::RST_FREQ;
         output_blank_interval     <= msms_pkg::RST_BLANK;
         injection_time_setting    <= msms_pkg::RST_TIME;
         injection_current_setting <= msms_pkg::RST_LEVEL;
         bus_limit                 <= msms_pkg::RST_BUSLIM;
      end else if (do_write) begin
         case (aw_addr)
            msms_pkg::OFF_CTRL: begin
               stop_mode              <= wr_val[msms_pkg::CTRL_MODE_LSB +: 3];
               protection_option_bits <= wr_val[msms_pkg::CTRL_PROT_LSB +: 8];
            end
            msms_pkg::OFF_FREQ: injection_start_frequency <=
               (wr_val[15:0] > msms_pkg::MAX_FREQ) ?
               msms_pkg::MAX_FREQ : wr_val[15:0];
            msms_pkg::OFF_BLANK: output_blank_interval <=
               (wr_val[15:0] > msms_pkg::MAX_TIME) ?
               msms_pkg::MAX_TIME : wr_val[15:0];
            msms_pkg::OFF_TIME: injection_time_setting <=
               (wr_val[15:0] > msms_pkg::MAX_TIME) ?
               msms_pkg::MAX_TIME : wr_val[15:0];
            msms_pkg::OFF_LEVEL: injection_current_setting <=
               (wr_val[7:0] > msms_pkg::MAX_LEVEL) ?
               msms_pkg::MAX_LEVEL : wr_val[7:0];
            msms_pkg::OFF_BUSLIM: bus_limit <= wr_val[11:0];
            default: ;
         endcase
      end
   end

   // Current value of the addressed register, merged with strobes
   always_comb begin
      case (aw_addr)
         msms_pkg::OFF_CTRL:   wr_val = msms_merge({16'h0,
            protection_option_bits, 5'h0, stop_mode}, w_data, w_strb);
         msms_pkg::OFF_FREQ:   wr_val = msms_merge({16'h0,
            injection_start_frequency}, w_data, w_strb);
         msms_pkg::OFF_BLANK:  wr_val = msms_merge({16'h0,
            output_blank_interval}, w_data, w_strb);
         msms_pkg::OFF_TIME:   wr_val = msms_merge({16'h0,
            injection_time_setting}, w_data, w_strb);
         msms_pkg::OFF_LEVEL:  wr_val = msms_merge({24'h0,
            injection_current_setting}, w_data, w_strb);
         msms_pkg::OFF_BUSLIM: wr_val = msms_merge({20'h0, bus_limit},
            w_data, w_strb);
         default:              wr_val = 32'h0;
      endcase
   end

   // Read channel, one word per request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= msms_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= msms_pkg::RESP_OKAY;
            case (s_axi_araddr)
               msms_pkg::OFF_CTRL:   s_axi_rdata <= {16'h0,
                  protection_option_bits, 5'h0, stop_mode};
               msms_pkg::OFF_FREQ:   s_axi_rdata <= {16'h0,
                  injection_start_frequency};
               msms_pkg::OFF_BLANK:  s_axi_rdata <= {16'h0,
                  output_blank_interval};
               msms_pkg::OFF_TIME:   s_axi_rdata <= {16'h0,
                  injection_time_setting};
               msms_pkg::OFF_LEVEL:  s_axi_rdata <= {24'h0,
                  injection_current_setting};
               msms_pkg::OFF_BUSLIM: s_axi_rdata <= {20'h0, bus_limit};
               msms_pkg::OFF_STATUS: s_axi_rdata <= {21'h0, state,
                  stopped, inj_active, output_enable, slope_reduce,
                  reaccel, dwell_skip, 1'b0, run_s};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= msms_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Phase timers for blanking and injection
   msms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_blank_tmr (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .load     (state == msms_pkg::MSMS_DECEL &&
                 next_state == msms_pkg::MSMS_BLANK),
      .load_val (output_blank_interval),
      .done     (blank_done)
   );
   msms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_inj_tmr (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .load     (state == msms_pkg::MSMS_BLANK &&
                 next_state == msms_pkg::MSMS_INJECT),
      .load_val (injection_time_setting),
      .done     (inj_done)
   );

   // Sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         msms_pkg::MSMS_IDLE: begin
            if (run_s) next_state = msms_pkg::MSMS_RUN;
         end
         msms_pkg::MSMS_RUN: begin
            if (!run_s && mode == msms_pkg::MSMS_MODE_COAST)
               next_state = msms_pkg::MSMS_STOPPED;
            else if (!run_s)
               next_state = msms_pkg::MSMS_DECEL;
         end
         msms_pkg::MSMS_DECEL: begin
            if (run_s)
               next_state = msms_pkg::MSMS_RUN;
            else if (mode == msms_pkg::MSMS_MODE_DC &&
                     out_freq <= injection_start_frequency)
               next_state = msms_pkg::MSMS_BLANK;
            else if (out_freq == 16'h0)
               next_state = msms_pkg::MSMS_STOPPED;
         end
         msms_pkg::MSMS_BLANK: begin
            if (blank_done) next_state = msms_pkg::MSMS_INJECT;
         end
         msms_pkg::MSMS_INJECT: begin
            if (inj_done) next_state = msms_pkg::MSMS_STOPPED;
         end
         msms_pkg::MSMS_STOPPED: begin
            if (run_s) next_state = msms_pkg::MSMS_IDLE;
         end
         default: next_state = msms_pkg::MSMS_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) state <= msms_pkg::MSMS_IDLE;
      else          state <= next_state;
   end

   assign decel_now = (next_state == msms_pkg::MSMS_DECEL) && ramp_decel;
   assign bus_high  = dcbus_volt > bus_limit;

   // Outputs registered from the next state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ramp_to_zero    <= 1'b0;
         output_enable   <= 1'b0;
         inj_active      <= 1'b0;
         inj_current_ref <= 8'h00;
         dwell_skip      <= 1'b0;
         stopped         <= 1'b0;
      end else begin
         ramp_to_zero  <= next_state == msms_pkg::MSMS_DECEL;
         output_enable <= next_state == msms_pkg::MSMS_RUN ||
                          next_state == msms_pkg::MSMS_DECEL;
         inj_active      <= next_state == msms_pkg::MSMS_INJECT;
         inj_current_ref <= (next_state == msms_pkg::MSMS_INJECT) ?
                            injection_current_setting : 8'h00;
         dwell_skip <= next_state == msms_pkg::MSMS_DECEL &&
                       mode == msms_pkg::MSMS_MODE_DC &&
                       dwell_freq < injection_start_frequency;
         stopped <= next_state == msms_pkg::MSMS_STOPPED;
      end
   end

   // Power braking and stall prevention
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slope_reduce  <= 1'b0;
         reaccel       <= 1'b0;
         stall_prev_en <= 1'b0;
      end else begin
         slope_reduce <= decel_now && mode == msms_pkg::MSMS_MODE_POWER &&
                         bus_high;
         // One spare bit so a high limit cannot wrap the margin
         reaccel      <= decel_now && mode == msms_pkg::MSMS_MODE_POWER &&
                         {1'b0, dcbus_volt} >
                         {1'b0, bus_limit} + 13'(msms_pkg::REACCEL_MARGIN);
         stall_prev_en <= decel_now && mode != msms_pkg::MSMS_MODE_POWER &&
            protection_option_bits[msms_pkg::PROT_STALL_BIT];
      end
   end

   property p_dec_stop;
      @(posedge aclk) disable iff (!aresetn)
      (state == msms_pkg::MSMS_DECEL && !run_s && out_freq == 16'h0 &&
       mode == msms_pkg::MSMS_MODE_DEC) |=> stopped && !output_enable;
   endproperty
   a_dec_stop: assert property (p_dec_stop)
      else $error("Decel stop did not end at zero");
   property p_dc_entry;
      @(posedge aclk) disable iff (!aresetn)
      (state == msms_pkg::MSMS_DECEL && !run_s &&
       mode == msms_pkg::MSMS_MODE_DC &&
       out_freq <= injection_start_frequency) |=>
      state == msms_pkg::MSMS_BLANK;
   endproperty
   a_dc_entry: assert property (p_dc_entry)
      else $error("DC entry frequency missed");
   property p_blank;
      @(posedge aclk) disable iff (!aresetn)
      state == msms_pkg::MSMS_BLANK |-> !output_enable && !inj_active;
   endproperty
   a_blank: assert property (p_blank)
      else $error("Output not blocked in blanking");
   property p_inj_end;
      @(posedge aclk) disable iff (!aresetn)
      (state == msms_pkg::MSMS_INJECT && inj_done) |=>
      !inj_active && stopped;
   endproperty
   a_inj_end: assert property (p_inj_end)
      else $error("Injection did not end");
   property p_level;
      @(posedge aclk) disable iff (!aresetn)
      inj_active |-> inj_current_ref == $past(injection_current_setting);
   endproperty
   a_level: assert property (p_level)
      else $error("Injection level wrong");
   property p_coast;
      @(posedge aclk) disable iff (!aresetn)
      (state == msms_pkg::MSMS_RUN && !run_s &&
       mode == msms_pkg::MSMS_MODE_COAST) |=>
      !output_enable && !ramp_to_zero;
   endproperty
   a_coast: assert property (p_coast)
      else $error("Coast did not cut output");
   property p_decel_only;
      @(posedge aclk) disable iff (!aresetn)
      (slope_reduce || reaccel || stall_prev_en) |->
      state == msms_pkg::MSMS_DECEL && $past(ramp_decel);
   endproperty
   a_decel_only: assert property (p_decel_only)
      else $error("Regulation outside deceleration");
   property p_priority;
      @(posedge aclk) disable iff (!aresetn)
      mode == msms_pkg::MSMS_MODE_POWER |=> !stall_prev_en;
   endproperty
   a_priority: assert property (p_priority)
      else $error("Stall prevention not suppressed");
   property p_bus_limit;
      @(posedge aclk) disable iff (!aresetn)
      (dcbus_volt <= bus_limit) |=> !slope_reduce && !reaccel;
   endproperty
   a_bus_limit: assert property (p_bus_limit)
      else $error("Regulation below bus limit");
endmodule : msms_seq
`default_nettype wire

/* verification/msms_ramp_model.sv */
// Purpose: Ramp generator and DC bus model facing the sequencer
// Assumes: One frequency step per aclk
// Notes:   Bus is high only while braking above 0x200
`timescale 1ns/10ps
`default_nettype none
module msms_ramp_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ramp_to_zero,
   input  wire logic        output_enable,
   input  wire logic        slope_reduce,
   input  wire logic        reaccel,
   output var  logic [15:0] out_freq,
   output var  logic        ramp_decel,
   output var  logic [11:0] dcbus_volt
);
   // Ramp up, down on request, slower while regulated
   always_ff @(posedge aclk) begin
      if (!aresetn || !output_enable) begin
         out_freq   <= 16'h0000;
         ramp_decel <= 1'b0;
      end else if (ramp_to_zero) begin
         ramp_decel <= (out_freq != 16'h0000);
         if (slope_reduce || reaccel)
            out_freq <= out_freq - 16'h0010;
         else if (out_freq >= 16'h0040)
            out_freq <= out_freq - 16'h0040;
         else
            out_freq <= 16'h0000;
      end else begin
         ramp_decel <= 1'b0;
         if (out_freq < 16'h0300)
            out_freq <= out_freq + 16'h0040;
      end
   end
   // Regenerated energy lifts the bus
   assign dcbus_volt = (ramp_decel && out_freq > 16'h0200) ? 12'hD00 : 12'h800;
endmodule : msms_ramp_model
`default_nettype wire

/* verification/tb_msms_seq.sv */
// Purpose: Self-checking bench for the stop-mode sequencer
// Assumes: TICK_CYCLES of 4, one 0.01 s unit is 4 aclk
// Notes:   Ramp and bus voltage come from the ramp model
`timescale 1ns/10ps
`default_nettype none
module tb_msms_seq;
   logic        aclk;
   logic        aresetn = 1'b0, run_cmd = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [15:0] dwell_freq = 16'h0080;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, ramp_to_zero, output_enable, inj_active;
   logic        dwell_skip, slope_reduce, reaccel, stall_prev_en, stopped;
   logic        ramp_decel;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] s_axi_rdata, rd;
   logic [7:0]  inj_current_ref, lvl;
   logic [15:0] out_freq, f_off;
   logic [11:0] dcbus_volt;
   logic [5:0]  saw;
   int          n_mismatch, check_count, t_off, n_blank, n_inj;
   logic [7:0]  offs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
   logic [31:0] rstv[6] = '{32'h0, 32'h1F4, 32'hA, 32'h64, 32'h32,
                            32'hC00};

   msms_seq #(.TICK_CYCLES(4)) dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_cmd,
      .out_freq, .ramp_decel, .dwell_freq, .dcbus_volt, .ramp_to_zero,
      .output_enable, .inj_active, .inj_current_ref, .dwell_skip,
      .slope_reduce, .reaccel, .stall_prev_en, .stopped);
   msms_ramp_model ramp (.aclk, .aresetn, .ramp_to_zero, .output_enable,
      .slope_reduce, .reaccel, .out_freq, .ramp_decel, .dcbus_volt);

   // 40 MHz clock
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rdr

   // Run up to full speed, drop the command, watch the stop
   task automatic stop_run();
      int n;
      saw = '0;
      n_blank = 0;
      n_inj = 0;
      t_off = -1;
      run_cmd <= 1'b1;
      for (n = 0; n < 200 && out_freq != 16'h0300; n++) begin
         @(posedge aclk);
         saw[5] |= slope_reduce | reaccel | stall_prev_en;
      end
      run_cmd <= 1'b0;
      for (n = 0; n < 400 && !stopped; n++) begin
         @(posedge aclk);
         saw[4:0] |= {stall_prev_en, reaccel, slope_reduce, dwell_skip,
                      ramp_to_zero};
         if (!output_enable && t_off < 0) begin
            t_off = n;
            f_off = out_freq;
         end
         if (t_off >= 0 && !output_enable && !inj_active && !stopped)
            n_blank++;
         if (inj_active) begin
            n_inj++;
            lvl = inj_current_ref;
         end
      end
   endtask : stop_run

   task automatic results();
      $display("Checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   // Main sequence: reset, settings, every stop mode
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 6; i++) begin
         rdr(offs[i]);
         chk(rd, rstv[i]);
      end
      wr(8'h10, 32'h1FF);
      rdr(8'h10);
      chk(rd, 32'hC8);
      wr(8'h18, 32'h1);
      chk(rs, 2'h2);
      rdr(8'h1C);
      chk(rs, 2'h2);
      wr(8'h04, 32'h100);
      wr(8'h08, 32'h1);
      wr(8'h0C, 32'h2);
      wr(8'h10, 32'h64);
      $display("Register test done");
      for (int m = 0; m < 6; m++) begin
         wr(8'h00, 32'h0800 | m);
         stop_run();
         chk(saw[0], m != 2);
         chk(n_inj != 0, m == 1);
         chk(saw[2], m == 4);
         chk(saw[3], m == 4);
         chk(saw[4], m != 2 && m != 4);
         chk(saw[5], 1'b0);
         chk(saw[1], m == 1);
         chk(stopped, 1'b1);
         // Status: state code 7, stopped bit, all else low
         rdr(8'h18);
         chk(rd, 32'h780);
         if (m == 2) begin
            chk(t_off <= 5, 1'b1);
         end else if (m != 1) begin
            chk(f_off, 16'h0);
         end else begin
            chk(f_off <= 16'h0100, 1'b1);
            chk(n_blank inside {[4:7]}, 1'b1);
            chk(n_inj inside {[8:9]}, 1'b1);
            chk(lvl, 8'h64);
         end
         $display("Stop test mode %0d done", m);
      end
      results();
   end

   // Watchdog against a hung handshake or sequence
   initial begin
      #(25 * 10000);
      n_mismatch++;
      results();
   end
endmodule : tb_msms_seq
`default_nettype wire
